// file: gray_level_duration_table_cfg.svh
// Offsets, reset values, field positions and timing counts of the table
`ifndef GRAY_LEVEL_DURATION_TABLE_CFG_SVH
`define GRAY_LEVEL_DURATION_TABLE_CFG_SVH

// Command codes, also the word index of each entry on the bus
`define CODE_ODD_LEVEL5     8'h29
`define CODE_ODD_LEVEL4     8'h2A
`define CODE_ODD_LEVEL3     8'h2B
`define CODE_ODD_LEVEL2     8'h2C
`define CODE_ODD_LEVEL1     8'h2D
`define CODE_EVEN_LEVEL15   8'h2E
`define CODE_EVEN_LEVEL14   8'h2F
`define CODE_EVEN_LEVEL13   8'h30
`define CODE_EVEN_LEVEL12   8'h31
`define CODE_FIRST          8'h29
`define CODE_LAST           8'h31

// Entry reset values
`define RST_ODD_LEVEL5      8'h05
`define RST_ODD_LEVEL4      8'h03
`define RST_ODD_LEVEL3      8'h02
`define RST_ODD_LEVEL2      8'h01
`define RST_ODD_LEVEL1      8'h00
`define RST_EVEN_LEVEL15    8'hFF
`define RST_EVEN_LEVEL14    8'hAF
`define RST_EVEN_LEVEL13    8'h79
`define RST_EVEN_LEVEL12    8'h53

// Own registers, byte addresses
`define ADDR_CTRL           12'h100
`define ADDR_STATUS         12'h104
`define ADDR_CMD            12'h108

// Control fields
`define CTRL_RUN_BIT        0
`define CTRL_SEL_LSB        4
`define CTRL_SEL_MSB        7

// Command word fields
`define CMD_CODE_LSB        8
`define CMD_CODE_MSB        15
`define CMD_DATA_LSB        0
`define CMD_DATA_MSB        7

// Status fields
`define STAT_ACTIVE_BIT     0
`define STAT_REMAIN_LSB     8
`define STAT_REMAIN_MSB     15
`define STAT_DUR_LSB        16
`define STAT_DUR_MSB        23
`define STAT_SEL_LSB        24
`define STAT_SEL_MSB        27

// System clock cycles per gray-step period
`define STEP_DIV_DEFAULT    4

`endif

// file: gray_level_duration_table_pkg.sv
// Types shared by the gray level duration table
package gray_level_duration_table_pkg;

   typedef logic [7:0] duration_t;
   typedef logic [3:0] entry_idx_t;

   typedef enum logic [0:0]
   {
      ENG_IDLE,
      ENG_COUNT
   } engine_e;

   localparam int ENTRY_COUNT = 9;

endpackage : gray_level_duration_table_pkg

// file: gray_level_duration_table.sv
// Gray level duration table with APB access and a period engine
//
// Contract
// - Entry is 8-bit; duration equals entry plus one gray-step period.
// - Entries are write-only; only status returns the selected entry, as sampled at period start.
// - Code 0x29 loads odd level 5 entry; resets to 0x05.
// - Code 0x2A loads odd level 4 entry; resets to 0x03.
// - Code 0x2B loads odd level 3 entry; resets to 0x02.
// - Code 0x2C loads odd level 2 entry; resets to 0x01.
// - Code 0x2D loads odd level 1 entry; resets to 0x00.
// - Code 0x2E loads even level 15 entry; resets to 0xFF.
// - Code 0x2F loads even level 14 entry; resets to 0xAF.
// - Code 0x30 loads even level 13 entry; resets to 0x79.
// - Code 0x31 loads even level 12 entry; resets to 0x53.
`timescale 1ns/100ps
`include "gray_level_duration_table_cfg.svh"

module gray_level_duration_table
   import gray_level_duration_table_pkg::*;
#(
   parameter int STEP_DIV = `STEP_DIV_DEFAULT
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             gray_drive,
   output logic             period_end
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Maps a command code to a table index; bit 4 flags a valid code
   function automatic logic [4:0] code_to_index(input logic [7:0] code);
      logic [7:0] diff;
      diff = code - `CODE_FIRST;
      if ((code >= `CODE_FIRST) && (code <= `CODE_LAST))
         code_to_index = {1'b1, diff[3:0]};
      else
         code_to_index = 5'h00;
   endfunction : code_to_index

   function automatic duration_t reset_duration(input int idx);
      case (idx)
         0:       reset_duration = `RST_ODD_LEVEL5;
         1:       reset_duration = `RST_ODD_LEVEL4;
         2:       reset_duration = `RST_ODD_LEVEL3;
         3:       reset_duration = `RST_ODD_LEVEL2;
         4:       reset_duration = `RST_ODD_LEVEL1;
         5:       reset_duration = `RST_EVEN_LEVEL15;
         6:       reset_duration = `RST_EVEN_LEVEL14;
         7:       reset_duration = `RST_EVEN_LEVEL13;
         8:       reset_duration = `RST_EVEN_LEVEL12;
         default: reset_duration = 8'h00;
      endcase
   endfunction : reset_duration

   ////////////////////////////////////////////////////////////////////////
   // State

   duration_t  table_ff [ENTRY_COUNT];
   logic       run_ff;
   entry_idx_t sel_ff;
   engine_e    state_ff;
   duration_t  remain_ff;
   duration_t  dur_ff;
   logic [7:0] div_ff;
   logic       step_ff;
   logic [31:0] prdata_ff;
   logic       pready_ff;
   logic       pslverr_ff;
   logic       drive_ff;
   logic       pend_ff;

   ////////////////////////////////////////////////////////////////////////
   // APB decode

   wire logic       setup_phase = psel & ~penable & ~pready_ff;
   wire logic       wr_commit   = psel & penable & pready_ff & pwrite;
   wire logic [7:0] word_index  = paddr[9:2];
   // Own registers: 100h control (run, select), 104h status, 108h command.
   // Table words sit at four times their command code and need an aligned
   // address; a stray byte offset is answered as unmapped.
   wire logic       hi_zero     = (paddr[11:10] == 2'b00)
                                  && (paddr[1:0] == 2'b00);
   wire logic [4:0] direct_hit  = hi_zero ? code_to_index(word_index)
                                           : 5'h00;
   wire logic       hit_table   = direct_hit[4];
   wire logic       hit_ctrl    = (paddr == `ADDR_CTRL);
   wire logic       hit_status  = (paddr == `ADDR_STATUS);
   wire logic       hit_cmd     = (paddr == `ADDR_CMD);
   wire logic       mapped      = hit_table | hit_ctrl | hit_status
                                  | hit_cmd;

   // Command word splits into code and data byte
   wire logic [7:0] cmd_code = pwdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
   wire logic [7:0] cmd_data = pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
   wire logic [4:0] cmd_hit  = code_to_index(cmd_code);

   // Direct writes need the low lane; command writes need both low lanes
   wire logic       wr_direct = wr_commit & hit_table & pstrb[0];
   wire logic       wr_cmd    = wr_commit & hit_cmd & (&pstrb[1:0])
                                & cmd_hit[4];
   wire logic       wr_ctrl   = wr_commit & hit_ctrl & pstrb[0];
   wire logic [3:0] wr_index  = wr_cmd ? cmd_hit[3:0] : direct_hit[3:0];
   wire duration_t  wr_value  = wr_cmd ? cmd_data : pwdata[7:0];
   wire logic       wr_entry  = wr_cmd | wr_direct;

   wire logic [31:0] status_word =
      {4'h0, sel_ff, dur_ff, remain_ff, 7'h00,
       (state_ff == ENG_COUNT)};

   // Table entries and the command port read back as zero
   wire logic [31:0] read_word =
      (!pwrite && hit_ctrl)   ? {24'h0, sel_ff, 3'h0, run_ff} :
      (!pwrite && hit_status) ? status_word :
                                32'h0;

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one cycle to register the answer, then pready

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end
      else if (setup_phase)
      begin
         pready_ff  <= 1'b1;
         pslverr_ff <= ~mapped;
         prdata_ff  <= mapped ? read_word : 32'h0;
      end
      else
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Table storage

   generate
      for (genvar i = 0; i < ENTRY_COUNT; i++)
      begin : g_entry
         always_ff @(posedge sys_clk)
         begin
            if (srst)
               table_ff[i] <= reset_duration(i);
            else if (wr_entry && (wr_index == 4'(i)))
               table_ff[i] <= wr_value;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         run_ff <= 1'b0;
         sel_ff <= 4'h0;
      end
      else if (wr_ctrl)
      begin
         run_ff <= pwdata[`CTRL_RUN_BIT];
         sel_ff <= pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gray-step divider

   localparam logic [7:0] DIV_LAST = 8'(STEP_DIV - 1);

   wire logic div_wrap = (div_ff == DIV_LAST);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         div_ff  <= 8'h00;
         step_ff <= 1'b0;
      end
      else
      begin
         div_ff  <= div_wrap ? 8'h00 : div_ff + 8'h01;
         step_ff <= div_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Period engine
   // A period spans entry+1 steps: the load step, then entry decrements.
   // The entry is sampled only at a period start, so a write in mid
   // period cannot cut or stretch the period already running.

   wire logic      sel_ok     = (sel_ff < 4'(ENTRY_COUNT));
   wire duration_t sel_value  = sel_ok ? table_ff[sel_ff] : 8'h00;
   wire logic      enable     = run_ff & sel_ok;
   wire logic      last_step  = (state_ff == ENG_COUNT) && step_ff
                                && (remain_ff == 8'h00);

   engine_e   nxt_state;
   duration_t nxt_remain;
   duration_t nxt_dur;

   always_comb
   begin
      nxt_state  = state_ff;
      nxt_remain = remain_ff;
      nxt_dur    = dur_ff;
      case (state_ff)
         ENG_IDLE:
         begin
            if (enable && step_ff)
            begin
               nxt_state  = ENG_COUNT;
               nxt_remain = sel_value;
               nxt_dur    = sel_value;
            end
         end
         ENG_COUNT:
         begin
            if (!enable)
               nxt_state = ENG_IDLE;
            else if (last_step)
            begin
               nxt_remain = sel_value;
               nxt_dur    = sel_value;
            end
            else if (step_ff)
               nxt_remain = remain_ff - 8'h01;
         end
         default:
            nxt_state = ENG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_ff  <= ENG_IDLE;
         remain_ff <= 8'h00;
         dur_ff    <= 8'h00;
         drive_ff  <= 1'b0;
         pend_ff   <= 1'b0;
      end
      else
      begin
         state_ff  <= nxt_state;
         remain_ff <= nxt_remain;
         dur_ff    <= nxt_dur;
         drive_ff  <= (nxt_state == ENG_COUNT);
         pend_ff   <= last_step & enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign gray_drive = drive_ff;
   assign period_end = pend_ff;

endmodule : gray_level_duration_table

// file: gray_level_duration_table_asserts.sv
// Bus and period engine checks for the gray level duration table
`timescale 1ns/100ps
module gray_level_duration_table_asserts
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        gray_drive,
   input wire logic        period_end
);
   wire tbl_hit = paddr >= 12'h0A4 && paddr <= 12'h0C4 && paddr[1:0] == 2'h0;
   wire own_hit = paddr == 12'h100 || paddr == 12'h104 || paddr == 12'h108;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   chk_ready_setup: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   chk_ready_pulse: assert property (
      pready |=> !pready) else $error("ready held too long");
   chk_err_unmapped: assert property (
      pready && !tbl_hit && !own_hit |-> pslverr) else $error("no error");
   chk_mapped_ok: assert property (
      pready && (tbl_hit || own_hit) |-> !pslverr) else $error("bad error");
   chk_err_with_ready: assert property (
      pslverr |-> pready) else $error("error without ready");
   chk_wo_read: assert property (
      pready && !pwrite && tbl_hit |-> prdata == 32'h0)
      else $error("table read returned data");
   chk_end_pulse: assert property (
      period_end |=> !period_end) else $error("period end too long");
   chk_end_drive: assert property (
      period_end |-> $past(gray_drive)) else $error("end while idle");
   chk_reset_quiet: assert property (
      $fell(srst) |-> !pready && !gray_drive && !period_end)
      else $error("outputs busy after reset");
endmodule : gray_level_duration_table_asserts

// file: gray_level_duration_table_host.sv
// Host model that issues register bus transfers to the table
`timescale 1ns/100ps
module gray_level_duration_table_host
(
   input  wire logic        sys_clk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   // Display is taken to be in 16-level mode, where every load is legal
   task automatic xfer
   (
      input  logic        w,
      input  logic [11:0] a,
      input  logic [31:0] d,
      input  logic [3:0]  s,
      output logic [31:0] r,
      output logic        e
   );
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      // No wait count assumed; the bench watchdog ends a hang
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : gray_level_duration_table_host

// file: gray_level_duration_table_tb.sv
// Self-checking bench for the gray level duration table
`timescale 1ns/100ps
module gray_level_duration_table_tb;
   localparam int STEP = 2;
   localparam logic [7:0] RST [9] = '{8'h05, 8'h03, 8'h02, 8'h01, 8'h00,
                                      8'hFF, 8'hAF, 8'h79, 8'h53};
   logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, er;
   logic        gray_drive, period_end;
   logic [11:0] paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, r;
   logic [31:0] lfsr = 32'h5964;
   logic [7:0]  v [9] = RST;
   int          bad_count = 0;
   int          checked = 0;
   time         t_mark;
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   gray_level_duration_table #(.STEP_DIV(STEP)) dut_u (.sys_clk(sys_clk),
      .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gray_drive(gray_drive),
      .period_end(period_end));
   gray_level_duration_table_host host_u (.sys_clk(sys_clk),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand
   // Clocks per period: entry plus one gray steps of STEP clocks each
   function automatic logic [31:0] exp_cycles(input logic [7:0] e);
      return (32'(e) + 32'h1) * STEP;
   endfunction : exp_cycles
   task check(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, s, x);
      end
   endtask : check
   task close_out;
      if (bad_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   // Restart the engine on one entry, time a full period, read it back
   task run_entry(input int i);
      time t0;
      host_u.xfer(1'b1, 12'h100, 32'h0, 4'hF, r, er);
      host_u.xfer(1'b1, 12'h100, {24'h0, i[3:0], 4'h1}, 4'hF, r, er);
      @(posedge sys_clk iff period_end === 1'b1);
      t0 = $time;
      @(posedge sys_clk iff period_end === 1'b1);
      check(32'(($time - t0) / 4), exp_cycles(v[i]));
      check({31'h0, gray_drive}, 32'h1);
      host_u.xfer(1'b0, 12'h104, 32'h0, 4'h0, r, er);
      check(32'(r[23:16]), 32'(v[i]));
      check({28'h0, r[27:24]}, 32'(i));
      check({31'h0, r[0]}, 32'h1);
   endtask : run_entry
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 9; i++)
         run_entry(i);
      for (int i = 0; i < 9; i++)
      begin
         lfsr = nxt_rand(lfsr);
         v[i] = i == 0 ? 8'hFF : i == 1 ? 8'h00 : lfsr[7:0];
         host_u.xfer(1'b1, 12'h108, {16'h0, 8'h29 + 8'(i), v[i]}, 4'h3,
                     r, er);
      end
      // Malformed commands and strobes must leave the table alone; the direct write to 0B0h then loads entry 3
      host_u.xfer(1'b1, 12'h108, 32'h3211, 4'h3, r, er);
      host_u.xfer(1'b1, 12'h108, 32'h2A11, 4'h1, r, er);
      host_u.xfer(1'b1, 12'h0A8, 32'h22, 4'hE, r, er);
      host_u.xfer(1'b1, 12'h0B0, 32'h7F, 4'hF, r, er);
      v[3] = 8'h7F;
      for (int i = 0; i < 9; i++)
         run_entry(i);
      host_u.xfer(1'b0, 12'h0B4, 32'h0, 4'h0, r, er);
      check(r, 32'h0);
      check({31'h0, er}, 32'h0);
      host_u.xfer(1'b0, 12'h108, 32'h0, 4'h0, r, er);
      check(r, 32'h0);
      host_u.xfer(1'b0, 12'h100, 32'h0, 4'h0, r, er);
      check(r, 32'h81);
      host_u.xfer(1'b0, 12'h200, 32'h0, 4'h0, r, er);
      check({31'h0, er}, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      v = RST;
      run_entry(5);
      // A write in mid period must leave the running period alone
      @(posedge sys_clk iff period_end === 1'b1);
      t_mark = $time;
      host_u.xfer(1'b1, 12'h108, 32'h2E10, 4'h3, r, er);
      @(posedge sys_clk iff period_end === 1'b1);
      check(32'(($time - t_mark) / 4), exp_cycles(RST[5]));
      t_mark = $time;
      @(posedge sys_clk iff period_end === 1'b1);
      check(32'(($time - t_mark) / 4), exp_cycles(8'h10));
      close_out();
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      close_out();
   end
endmodule : gray_level_duration_table_tb
bind gray_level_duration_table gray_level_duration_table_asserts chk_u (
   .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .gray_drive(gray_drive), .period_end(period_end));
